// [hw/drt_divider.sv]
// System clock divider with hold and skip inputs for rate trimming.
// Assumes hold and extra are steady while o_osc_tick is high.
`timescale 1ns/1ps
module drt_divider
  import drt_pkg::*;
#(
  parameter int OSC_DIV = DRT_OSC_DIV,
  parameter int DIV_W = DRT_DIV_W
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Correction control
  input wire logic i_hold,
  input wire logic [3:0] i_extra,
  // Divider outputs
  output logic o_osc_tick,
  output logic [DIV_W-1:0] o_div_count
);

  localparam int PRE_W = $clog2(OSC_DIV);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(OSC_DIV - 1);

  if (OSC_DIV < 2 || DIV_W <= DRT_TAP_64) begin : g_bad_param
    $error("drt_divider: OSC_DIV or DIV_W out of range");
  end

  logic [PRE_W-1:0] pre_reg;
  logic [PRE_W-1:0] pre_next;
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic tick;

  // ---------------------------------------------------------------
  // Prescaler and corrected count
  // ---------------------------------------------------------------
  always_comb begin
    tick = (pre_reg == PRE_LAST);
    pre_next = tick ? '0 : pre_reg + PRE_W'(1);
    cnt_next = cnt_reg;
    if (tick && !i_hold) begin
      cnt_next = cnt_reg + DIV_W'(1) + DIV_W'(i_extra);
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pre_reg <= '0;
      cnt_reg <= '0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
    end
  end

  assign o_osc_tick = tick;
  assign o_div_count = cnt_reg;

endmodule : drt_divider

// [hw/drt_pkg.sv]
// Constants, types and register map of the divider rate trim block.
// Assumes a single 20 MHz clock and a 4-bit CPU I/O bus with strobes.
//
// Summary of operation
// - Monitor pin shows trigger pulse when enabled
// - One trigger write gives one correction session
// - Writing zero to trigger does nothing
// - Trigger bit reads one while session runs
// - Start at 512 Hz fall coinciding with 64 Hz fall
// - Start lags up to 16.6 ms; retriggers ignored
// - Reset clears trigger and monitor enable
// - Pin data bits read pin levels, read-only
// - Reading pin data captures the correction value
// - Captured registers read-only, reset to zero
// - Sign one shortens by 15 minus magnitude
// - Sign zero lengthens by magnitude plus one
// - Correction applied inside the system divider
package drt_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] DRT_ADDR_MAG_PINS = 16'hFF29;
  localparam logic [15:0] DRT_ADDR_MAG_CAP = 16'hFF2A;
  localparam logic [15:0] DRT_ADDR_MON_SIGN = 16'hFF2D;
  localparam logic [15:0] DRT_ADDR_SIGN_CAP = 16'hFF2E;
  localparam logic [15:0] DRT_ADDR_REG_CTRL = 16'hFF88;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DRT_BIT_TRIGGER = 0;
  localparam int DRT_BIT_MON_EN = 1;
  localparam int DRT_BIT_SIGN_PIN = 0;
  localparam int DRT_BIT_LIMIT_STAT = 1;
  localparam int DRT_BIT_LIMIT_EN = 2;
  localparam int DRT_BIT_SOLAR_EN = 3;
  localparam int DRT_BIT_SIGN_CAP = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic DRT_RST_MON_EN = 1'h0;
  localparam logic DRT_RST_OTHER_EN = 1'h0;
  localparam logic [3:0] DRT_RST_MAG_CAP = 4'h0;
  localparam logic DRT_RST_SIGN_CAP = 1'h0;

  // ---------------------------------------------------------------
  // Divider layout and timing
  // ---------------------------------------------------------------
  localparam int DRT_DIV_W = 15;
  localparam int DRT_TAP_512 = 5;
  localparam int DRT_TAP_64 = 8;
  localparam logic [3:0] DRT_SHORT_BASE = 4'hF;
  localparam int DRT_CLK_HZ = 20000000;
  localparam int DRT_OSC_HZ = 32768;
  localparam int DRT_OSC_DIV = DRT_CLK_HZ / DRT_OSC_HZ;
  localparam int DRT_PEND_MAX_US = 16600;
  localparam int DRT_PEND_MAX_CYC =
    DRT_PEND_MAX_US * (DRT_CLK_HZ / 1000000);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DRT_IDLE = 2'b00,
    DRT_PEND = 2'b01,
    DRT_APPLY = 2'b10
  } drt_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [3:0] wdata;
  } drt_bus_t;

endpackage : drt_pkg

// [hw/drt_trim.sv]
// Rate trim top: register file, correction sequencer, monitor pin.
// Assumes pins are synchronous and the CPU bus gives one-cycle strobes.
`timescale 1ns/1ps
module drt_trim
  import drt_pkg::*;
#(
  parameter int OSC_DIV = DRT_OSC_DIV,
  parameter int PEND_MAX_CYC = DRT_PEND_MAX_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // CPU I/O bus
  input wire drt_bus_t i_bus,
  output logic [3:0] o_rdata,
  // Correction pins
  input wire logic [3:0] i_mag_pins,
  input wire logic i_sign_pin,
  // Neighbour status and enables sharing a register
  input wire logic i_limit_level_status,
  output logic o_solar_monitor_enable,
  output logic o_limit_monitor_enable,
  // Monitor pin and divided clocks
  output logic o_monitor_pin,
  output logic [DRT_DIV_W-1:0] o_div_count
);

  if (PEND_MAX_CYC < 1) begin : g_bad_param
    $error("drt_trim: PEND_MAX_CYC must be positive");
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  function automatic logic hit(input drt_bus_t b, input logic [15:0] a);
    hit = (b.addr == a);
  endfunction : hit

  logic wr_ctrl;
  logic trig_wr_one;
  logic rd_mag_pins;
  logic rd_mon_sign;
  logic wr_mon_sign;

  always_comb begin
    wr_ctrl = i_bus.wr && hit(i_bus, DRT_ADDR_REG_CTRL);
    trig_wr_one = wr_ctrl && i_bus.wdata[DRT_BIT_TRIGGER];
    rd_mag_pins = i_bus.rd && hit(i_bus, DRT_ADDR_MAG_PINS);
    rd_mon_sign = i_bus.rd && hit(i_bus, DRT_ADDR_MON_SIGN);
    wr_mon_sign = i_bus.wr && hit(i_bus, DRT_ADDR_MON_SIGN);
  end

  // ---------------------------------------------------------------
  // Divider instance
  // ---------------------------------------------------------------
  drt_state_t st_reg;
  drt_state_t st_next;
  logic apply_sign_reg;
  logic apply_sign_next;
  logic [3:0] apply_mag_reg;
  logic [3:0] apply_mag_next;
  logic [4:0] rem_reg;
  logic [4:0] rem_next;
  logic hold;
  logic [3:0] extra;
  logic osc_tick;
  logic [DRT_DIV_W-1:0] div_count;
  logic [3:0] cap_mag_reg;
  logic [3:0] cap_mag_next;
  logic cap_sign_reg;
  logic cap_sign_next;
  logic tap512_reg;
  logic tap64_reg;
  logic fall512;
  logic fall64;
  logic start_evt;
  logic busy;

  drt_divider #(
    .OSC_DIV(OSC_DIV),
    .DIV_W(DRT_DIV_W)
  ) u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_hold(hold),
    .i_extra(extra),
    .o_osc_tick(osc_tick),
    .o_div_count(div_count)
  );

  assign o_div_count = div_count;

  // ---------------------------------------------------------------
  // Correction sequencer
  // ---------------------------------------------------------------
  always_comb begin
    busy = (st_reg != DRT_IDLE);
    fall512 = tap512_reg && !div_count[DRT_TAP_512];
    fall64 = tap64_reg && !div_count[DRT_TAP_64];
    start_evt = fall512 && fall64;
    hold = (st_reg == DRT_APPLY) && !apply_sign_reg;
    extra = '0;
    if (st_reg == DRT_APPLY && apply_sign_reg) begin
      extra = DRT_SHORT_BASE - apply_mag_reg;
    end
  end

  always_comb begin
    st_next = st_reg;
    apply_sign_next = apply_sign_reg;
    apply_mag_next = apply_mag_reg;
    rem_next = rem_reg;
    unique case (st_reg)
      DRT_IDLE: begin
        if (trig_wr_one) begin
          st_next = DRT_PEND;
          apply_sign_next = cap_sign_reg;
          apply_mag_next = cap_mag_reg;
          rem_next = {1'b0, cap_mag_reg} + 5'h01;
        end
      end
      DRT_PEND: begin
        if (start_evt) begin
          st_next = DRT_APPLY;
        end
      end
      DRT_APPLY: begin
        if (osc_tick) begin
          rem_next = rem_reg - 5'h01;
          if (apply_sign_reg || rem_reg == 5'h01) begin
            st_next = DRT_IDLE;
          end
        end
      end
      default: begin
        st_next = DRT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= DRT_IDLE;
      apply_sign_reg <= 1'h0;
      apply_mag_reg <= 4'h0;
      rem_reg <= 5'h00;
      tap512_reg <= 1'h0;
      tap64_reg <= 1'h0;
    end else begin
      st_reg <= st_next;
      apply_sign_reg <= apply_sign_next;
      apply_mag_reg <= apply_mag_next;
      rem_reg <= rem_next;
      tap512_reg <= div_count[DRT_TAP_512];
      tap64_reg <= div_count[DRT_TAP_64];
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic mon_en_reg;
  logic mon_en_next;
  logic solar_en_reg;
  logic solar_en_next;
  logic limit_en_reg;
  logic limit_en_next;
  logic [3:0] rdata_reg;
  logic [3:0] rdata_next;
  logic mon_pin_reg;
  logic mon_pin_next;

  always_comb begin
    mon_en_next = mon_en_reg;
    solar_en_next = solar_en_reg;
    limit_en_next = limit_en_reg;
    cap_mag_next = cap_mag_reg;
    cap_sign_next = cap_sign_reg;
    rdata_next = rdata_reg;
    if (wr_ctrl) begin
      mon_en_next = i_bus.wdata[DRT_BIT_MON_EN];
    end
    if (wr_mon_sign) begin
      solar_en_next = i_bus.wdata[DRT_BIT_SOLAR_EN];
      limit_en_next = i_bus.wdata[DRT_BIT_LIMIT_EN];
    end
    if (rd_mag_pins) begin
      cap_mag_next = i_mag_pins;
    end
    if (rd_mon_sign) begin
      cap_sign_next = i_sign_pin;
    end
    if (i_bus.rd) begin
      rdata_next = 4'h0;
      unique case (i_bus.addr)
        DRT_ADDR_MAG_PINS: rdata_next = i_mag_pins;
        DRT_ADDR_MAG_CAP: rdata_next = cap_mag_reg;
        DRT_ADDR_MON_SIGN: begin
          rdata_next[DRT_BIT_SOLAR_EN] = solar_en_reg;
          rdata_next[DRT_BIT_LIMIT_EN] = limit_en_reg;
          rdata_next[DRT_BIT_LIMIT_STAT] = i_limit_level_status;
          rdata_next[DRT_BIT_SIGN_PIN] = i_sign_pin;
        end
        DRT_ADDR_SIGN_CAP: rdata_next[DRT_BIT_SIGN_CAP] = cap_sign_reg;
        DRT_ADDR_REG_CTRL: begin
          rdata_next[DRT_BIT_MON_EN] = mon_en_reg;
          rdata_next[DRT_BIT_TRIGGER] = busy;
        end
        default: rdata_next = 4'h0;
      endcase
    end
    mon_pin_next = mon_en_reg && trig_wr_one;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mon_en_reg <= DRT_RST_MON_EN;
      solar_en_reg <= DRT_RST_OTHER_EN;
      limit_en_reg <= DRT_RST_OTHER_EN;
      cap_mag_reg <= DRT_RST_MAG_CAP;
      cap_sign_reg <= DRT_RST_SIGN_CAP;
      rdata_reg <= 4'h0;
      mon_pin_reg <= 1'h0;
    end else begin
      mon_en_reg <= mon_en_next;
      solar_en_reg <= solar_en_next;
      limit_en_reg <= limit_en_next;
      cap_mag_reg <= cap_mag_next;
      cap_sign_reg <= cap_sign_next;
      rdata_reg <= rdata_next;
      mon_pin_reg <= mon_pin_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_monitor_pin = mon_pin_reg;
  assign o_solar_monitor_enable = solar_en_reg;
  assign o_limit_monitor_enable = limit_en_reg;

  // ---------------------------------------------------------------
  // Assertion helpers
  // ---------------------------------------------------------------
  logic [31:0] pend_cnt;
  logic [4:0] held_cnt;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pend_cnt <= '0;
      held_cnt <= '0;
    end else begin
      pend_cnt <= (st_reg == DRT_PEND) ? pend_cnt + 32'h1 : 32'h0;
      if (st_reg == DRT_PEND) begin
        held_cnt <= '0;
      end else if (osc_tick && hold) begin
        held_cnt <= held_cnt + 5'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_accept;
    trig_wr_one && st_reg == DRT_IDLE;
  endsequence

  sequence s_pending;
    st_reg == DRT_PEND;
  endsequence

  property p_one_session;
    s_accept |=> s_pending;
  endproperty

  chk_mon_pulse_on: assert property (
    trig_wr_one && mon_en_reg |=> o_monitor_pin)
    else $error("monitor pin missed trigger pulse");

  chk_mon_pin_cause: assert property (
    o_monitor_pin |-> $past(trig_wr_one) && $past(mon_en_reg))
    else $error("monitor pin high without enabled trigger");

  chk_trig_accept: assert property (p_one_session)
    else $error("trigger write did not start a session");

  chk_zero_write: assert property (
    wr_ctrl && !trig_wr_one && st_reg == DRT_IDLE |=> !busy)
    else $error("zero write started a session");

  chk_pend_ignore: assert property (
    s_pending ##0 (trig_wr_one && !start_evt) |=> st_reg == DRT_PEND
      && $stable(apply_mag_reg) && $stable(apply_sign_reg))
    else $error("retrigger during pending interval took effect");

  chk_start_align: assert property (
    $rose(st_reg == DRT_APPLY) |-> $past(start_evt)
      && $past(div_count[DRT_TAP_64:0]) == '0)
    else $error("correction started off the tick alignment");

  chk_pend_bound: assert property (
    pend_cnt <= 32'(PEND_MAX_CYC))
    else $error("pending interval exceeded its bound");

  chk_status_read: assert property (
    i_bus.rd && i_bus.addr == DRT_ADDR_REG_CTRL
      |=> o_rdata[DRT_BIT_TRIGGER] == $past(busy)
      && o_rdata[3:2] == 2'h0)
    else $error("trigger bit read disagrees with session state");

  chk_lengthen_len: assert property (
    $fell(busy) && !apply_sign_reg
      |-> {1'b0, held_cnt} == {2'h0, apply_mag_reg} + 6'h01)
    else $error("lengthen step held wrong number of ticks");

  chk_shorten_amt: assert property (
    st_reg == DRT_APPLY && apply_sign_reg && osc_tick
      |=> !busy && div_count == $past(div_count)
      + DRT_DIV_W'(5'h10 - {1'b0, apply_mag_reg}))
    else $error("shorten step applied wrong amount");

  chk_capture: assert property (
    rd_mag_pins |=> cap_mag_reg == $past(i_mag_pins))
    else $error("magnitude capture missed pin read");

  chk_cap_ro: assert property (
    i_bus.wr && !rd_mag_pins |=> $stable(cap_mag_reg))
    else $error("captured magnitude changed by a write");

endmodule : drt_trim

// [test/drt_trim_bench.sv]
// Self-checking bench for the divider rate trim block.
// Assumes OSC_DIV is shortened to 4 so the divider taps come round fast.
`timescale 1ns/1ps
module drt_trim_bench;
  import drt_pkg::*;
  localparam int OSC = 4;
  localparam int WIN = 2800;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  drt_bus_t i_bus = '0;
  logic [3:0] o_rdata;
  logic [3:0] i_mag_pins = 4'h0;
  logic i_sign_pin = 1'b0;
  logic i_limit_level_status = 1'b0;
  logic o_solar_monitor_enable;
  logic o_limit_monitor_enable;
  logic o_monitor_pin;
  logic [DRT_DIV_W-1:0] o_div_count;
  logic [DRT_DIV_W-1:0] prev_cnt = '0;
  logic [DRT_DIV_W-1:0] anom_val = '0;
  logic [DRT_DIV_W-1:0] dlt;
  logic [3:0] rd;
  int gap = 0;
  int anom_n = 0;
  int pulse_n = 0;
  int miscompares = 0;
  int num_checks = 0;

  always #25 i_clk_sys = ~i_clk_sys;

  drt_trim #(.OSC_DIV(OSC), .PEND_MAX_CYC(2400)) dut (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_bus(i_bus),
    .o_rdata(o_rdata),
    .i_mag_pins(i_mag_pins),
    .i_sign_pin(i_sign_pin),
    .i_limit_level_status(i_limit_level_status),
    .o_solar_monitor_enable(o_solar_monitor_enable),
    .o_limit_monitor_enable(o_limit_monitor_enable),
    .o_monitor_pin(o_monitor_pin),
    .o_div_count(o_div_count)
  );

  // ---------------------------------------------------------------
  // Divider watcher: flags stalls and jumps, counts monitor pulses
  // ---------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (o_monitor_pin === 1'b1) begin
      pulse_n = pulse_n + 1;
    end
    dlt = o_div_count - prev_cnt;
    if (o_div_count !== prev_cnt) begin
      if (dlt !== 15'h0001 || gap > OSC) begin
        anom_n = anom_n + 1;
        anom_val = prev_cnt;
      end
      gap = 1;
    end else begin
      gap = gap + 1;
    end
    prev_cnt = o_div_count;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [15:0] a, input logic [3:0] d);
    @(negedge i_clk_sys);
    i_bus.addr = a;
    i_bus.wdata = d;
    i_bus.wr = 1'b1;
    @(negedge i_clk_sys);
    i_bus.wr = 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, output logic [3:0] d);
    @(negedge i_clk_sys);
    i_bus.addr = a;
    i_bus.rd = 1'b1;
    @(negedge i_clk_sys);
    i_bus.rd = 1'b0;
    d = o_rdata;
  endtask : bus_rd

  task automatic rd_chk(input logic [15:0] a, input logic [3:0] exp);
    bus_rd(a, rd);
    check(rd, exp);
  endtask : rd_chk

  task automatic do_reset;
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    i_rst = 1'b0;
    check(o_monitor_pin, 1'b0);
    check({o_solar_monitor_enable, o_limit_monitor_enable}, 2'b00);
    rd_chk(DRT_ADDR_REG_CTRL, 4'h0);
    rd_chk(DRT_ADDR_MAG_CAP, 4'h0);
    rd_chk(DRT_ADDR_SIGN_CAP, 4'h0);
  endtask : do_reset

  task automatic test_done;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    i_mag_pins = 4'hA;
    i_sign_pin = 1'b1;
    i_limit_level_status = 1'b1;
    bus_wr(DRT_ADDR_MAG_PINS, 4'h5);
    rd_chk(DRT_ADDR_MAG_PINS, 4'hA);
    bus_wr(DRT_ADDR_MAG_CAP, 4'h5);
    rd_chk(DRT_ADDR_MAG_CAP, 4'hA);
    bus_wr(DRT_ADDR_MON_SIGN, 4'hC);
    rd_chk(DRT_ADDR_MON_SIGN, 4'hF);
    check({o_solar_monitor_enable, o_limit_monitor_enable}, 2'b11);
    bus_wr(DRT_ADDR_SIGN_CAP, 4'hE);
    rd_chk(DRT_ADDR_SIGN_CAP, 4'h1);
    i_sign_pin = 1'b0;
    i_limit_level_status = 1'b0;
    bus_wr(DRT_ADDR_MON_SIGN, 4'h3);
    rd_chk(DRT_ADDR_MON_SIGN, 4'h0);
    check({o_solar_monitor_enable, o_limit_monitor_enable}, 2'b00);
    rd_chk(16'hFF30, 4'h0);
    bus_wr(DRT_ADDR_REG_CTRL, 4'hE);
    check(o_monitor_pin, 1'b0);
    rd_chk(DRT_ADDR_REG_CTRL, 4'h2);
  endtask : t_regs

  task automatic t_session(input logic sgn, input logic [3:0] mag,
                           input logic en);
    logic [DRT_DIV_W-1:0] c0;
    logic [DRT_DIV_W-1:0] want;
    time t0;
    int exp_n;
    want = DRT_DIV_W'(WIN / OSC);
    if (sgn) begin
      want = want + DRT_DIV_W'(15 - mag);
    end else begin
      want = want - DRT_DIV_W'(mag + 1);
    end
    exp_n = (sgn && mag == 4'hF) ? 0 : 1;
    i_mag_pins = mag;
    i_sign_pin = sgn;
    bus_rd(DRT_ADDR_MAG_PINS, rd);
    bus_rd(DRT_ADDR_MON_SIGN, rd);
    bus_wr(DRT_ADDR_REG_CTRL, {2'b00, en, 1'b0});
    while (o_div_count[DRT_TAP_64:0] != 9'h010) begin
      @(negedge i_clk_sys);
    end
    c0 = o_div_count;
    t0 = $time;
    anom_n = 0;
    pulse_n = 0;
    bus_wr(DRT_ADDR_REG_CTRL, {2'b00, en, 1'b1});
    check(o_monitor_pin, en);
    rd_chk(DRT_ADDR_REG_CTRL, {2'b00, en, 1'b1});
    bus_wr(DRT_ADDR_REG_CTRL, {2'b00, en, 1'b0});
    bus_wr(DRT_ADDR_REG_CTRL, {2'b00, en, 1'b1});
    i_mag_pins = ~mag;
    i_sign_pin = ~sgn;
    bus_rd(DRT_ADDR_MAG_PINS, rd);
    bus_rd(DRT_ADDR_MON_SIGN, rd);
    while ($time - t0 < WIN * 50) begin
      @(negedge i_clk_sys);
    end
    check(o_div_count - c0, want);
    check(15'(anom_n), 15'(exp_n));
    if (exp_n == 1) begin
      check(anom_val[8:0], 9'h000);
      check(anom_val[8], 1'b0);
    end
    check(15'(pulse_n), en ? 15'h0002 : 15'h0000);
    rd_chk(DRT_ADDR_REG_CTRL, {2'b00, en, 1'b0});
    rd_chk(DRT_ADDR_MAG_CAP, ~mag);
    rd_chk(DRT_ADDR_SIGN_CAP, {3'b000, ~sgn});
  endtask : t_session

  task automatic t_reset_mid;
    bus_wr(DRT_ADDR_MON_SIGN, 4'hC);
    bus_wr(DRT_ADDR_REG_CTRL, 4'h3);
    repeat (20) @(negedge i_clk_sys);
    do_reset();
  endtask : t_reset_mid

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(negedge i_clk_sys);
    i_rst = 1'b0;
    do_reset();
    t_regs();
    t_session(1'b0, 4'h0, 1'b1);
    t_session(1'b0, 4'hF, 1'b0);
    t_session(1'b1, 4'h0, 1'b1);
    t_session(1'b1, 4'hF, 1'b1);
    t_session(1'b1, 4'h5, 1'b0);
    t_reset_mid();
    test_done();
  end

  initial begin
    #(40000 * 50);
    miscompares++;
    test_done();
  end
endmodule : drt_trim_bench
